// ---- cpfg_pkg.sv ----
package cpfg_pkg;
  localparam int NUM_CH = 5;
  localparam int CNT_W = 16;
  localparam int DUTY_W = 17;
  localparam int NUM_BASE = 5;
  localparam int DECADE = 10;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REF_PERIOD_PS = 1000000;
  localparam int REF_DIV = REF_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [DUTY_W-1:0] DUTY_ONE = 17'h10000;
  localparam logic [CNT_W-1:0] ARM_HALF = 16'h8000;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 17'h00000;
  localparam logic LEVEL_RST = 1'b0;
  localparam logic ARM_RST = 1'b0;

  typedef enum logic [2:0] {BASE_1M, BASE_100K, BASE_10K, BASE_1K, BASE_100} cpfg_base_e;
  typedef enum logic [1:0] {MODE_PWM, MODE_PWM_ARM, MODE_FM} cpfg_mode_e;
endpackage

// ---- cpfg_prescale.sv ----
`timescale 1ns/100ps
module cpfg_prescale #(
  parameter int DIV = cpfg_pkg::REF_DIV
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  output logic [cpfg_pkg::NUM_BASE-1:0] tick_o
);
  import cpfg_pkg::*;

  localparam int REF_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [REF_W-1:0] REF_LAST = REF_W'(DIV - 1);
  localparam logic [3:0] DEC_LAST = 4'(DECADE - 1);

  if (DIV < 1) begin : g_bad_div
    $error("prescale divider must be at least 1");
  end

  logic [REF_W-1:0] ref_q, ref_d;
  logic [NUM_BASE-1:1][3:0] dec_q, dec_d;
  logic [NUM_BASE-1:0] tick_d;

  // 1 mhz reference from the core clock
  // decade chain down to 100 hz
  always_comb begin
    ref_d = (ref_q == REF_LAST) ? '0 : REF_W'(ref_q + 1'b1);
    tick_d[0] = (ref_q == REF_LAST);
    dec_d = dec_q;
    for (int k = 1; k < NUM_BASE; k++) begin
      tick_d[k] = tick_d[k-1] && (dec_q[k] == DEC_LAST);
      if (tick_d[k-1]) begin
        dec_d[k] = (dec_q[k] == DEC_LAST) ? 4'h0 : 4'(dec_q[k] + 4'h1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ref_q <= '0;
      dec_q <= '0;
      tick_o <= '0;
    end else begin
      ref_q <= ref_d;
      dec_q <= dec_d;
      tick_o <= tick_d;
    end
  end

  sequence seq_ref_quiet;
    !tick_o[0] [*8];
  endsequence

  chk_ref_tick_spacing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tick_o[0] |=> seq_ref_quiet)
    else $error("reference ticks too close");

  chk_decade_nesting: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick_o[4] |-> &tick_o[3:0]) and (tick_o[1] |-> tick_o[0]))
    else $error("decade tick without faster tick");
endmodule // cpfg_prescale

// ---- cpfg_top.sv ----
`timescale 1ns/100ps
module cpfg_top #(
  parameter int NUM_CH = cpfg_pkg::NUM_CH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [NUM_CH-1:0] load_i,
  input wire cpfg_pkg::cpfg_mode_e mode_i [NUM_CH],
  input wire cpfg_pkg::cpfg_base_e base_i [NUM_CH],
  input wire logic [NUM_CH-1:0][cpfg_pkg::CNT_W-1:0] period_i,
  input wire logic [NUM_CH-1:0][cpfg_pkg::DUTY_W-1:0] duty_i,
  input wire logic [NUM_CH-1:0] level_i,
  input wire logic [NUM_CH-1:0] arm_init_i,
  input wire logic [NUM_CH-1:0] mod_valid_i,
  input wire logic [NUM_CH-1:0][cpfg_pkg::DUTY_W-1:0] mod_i,
  input wire logic [NUM_CH-1:0][cpfg_pkg::CNT_W-1:0] arm_i,
  output logic [NUM_CH-1:0] pwm_o,
  output logic [NUM_CH-1:0] armed_o,
  output logic [NUM_CH-1:0] period_start_o
);
  import cpfg_pkg::*;

  if (NUM_CH < 1) begin : g_bad_ch
    $error("at least one channel is needed");
  end

  function automatic logic [DUTY_W-1:0] clamp_duty(input logic [DUTY_W-1:0] d);
    return (d > DUTY_ONE) ? DUTY_ONE : d;
  endfunction

  // length of the leading part of the period in base ticks
  function automatic logic [CNT_W-1:0] hi_len(input logic [CNT_W-1:0] per, input logic [DUTY_W-1:0] d);
    logic [CNT_W+DUTY_W-1:0] prod;
    prod = per * clamp_duty(d);
    return prod[CNT_W+DUTY_W-2:DUTY_W-1];
  endfunction

  function automatic logic runs(input logic run, input cpfg_mode_e m, input logic arm,
                                input logic [CNT_W-1:0] per);
    return run && ((m != MODE_PWM_ARM) || arm) && (per != '0);
  endfunction

  logic [NUM_BASE-1:0] tick;

  cpfg_prescale #(
    .DIV(REF_DIV)
  ) u_prescale (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  cpfg_mode_e mode_q [NUM_CH];
  cpfg_mode_e mode_d [NUM_CH];
  cpfg_base_e base_q [NUM_CH];
  cpfg_base_e base_d [NUM_CH];
  logic [NUM_CH-1:0][CNT_W-1:0] cnt_q, cnt_d, period_q, period_d, hi_q, hi_d, pend_per_q, pend_per_d;
  logic [NUM_CH-1:0][DUTY_W-1:0] duty_q, duty_d, pend_duty_q, pend_duty_d;
  logic [NUM_CH-1:0] level_q, level_d, arm_q, arm_d, run_q, run_d, pend_q, pend_d;
  logic [NUM_CH-1:0] out_d, start_d;

  always_comb begin
    logic go;
    logic tk;
    logic apply;
    go = 1'b0;
    tk = 1'b0;
    apply = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      mode_d[c] = mode_q[c];
      base_d[c] = base_q[c];
      cnt_d[c] = cnt_q[c];
      period_d[c] = period_q[c];
      duty_d[c] = duty_q[c];
      pend_per_d[c] = pend_per_q[c];
      pend_duty_d[c] = pend_duty_q[c];
      level_d[c] = level_q[c];
      arm_d[c] = arm_q[c];
      run_d[c] = run_q[c];
      pend_d[c] = pend_q[c];
      start_d[c] = 1'b0;
      apply = 1'b0;
      if (load_i[c]) begin
        // initial duty and frequency taken at load
        // frequency mode starts from loaded period
        // duty fixed from load in frequency mode
        mode_d[c] = mode_i[c];
        base_d[c] = base_i[c];
        period_d[c] = period_i[c];
        duty_d[c] = clamp_duty(duty_i[c]);
        level_d[c] = level_i[c];
        arm_d[c] = arm_init_i[c];
        run_d[c] = 1'b1;
        pend_d[c] = 1'b0;
        cnt_d[c] = '0;
      end else begin
        go = runs(run_q[c], mode_q[c], arm_q[c], period_q[c]);
        // each channel counts its own selected base
        tk = tick[base_q[c]];
        if (!go) begin
          // stopped channel restarts from period start
          cnt_d[c] = '0;
          apply = pend_q[c];
        end else if (tk) begin
          // period is the loaded count of base ticks
          if (cnt_q[c] == CNT_W'(period_q[c] - 1'b1)) begin
            cnt_d[c] = '0;
            start_d[c] = 1'b1;
            apply = pend_q[c];
          end else begin
            cnt_d[c] = CNT_W'(cnt_q[c] + 1'b1);
          end
        end
        // pending value applied at period end, or at once while stopped
        if (apply) begin
          if (mode_q[c] == MODE_FM) begin
            period_d[c] = pend_per_q[c];
          end else begin
            duty_d[c] = pend_duty_q[c];
          end
          pend_d[c] = 1'b0;
        end
        // one update per sample period expected
        if (mod_valid_i[c] && run_q[c]) begin
          pend_d[c] = 1'b1;
          unique case (mode_q[c])
            MODE_PWM: begin
              pend_duty_d[c] = clamp_duty(mod_i[c]);
            end
            MODE_PWM_ARM: begin
              pend_duty_d[c] = clamp_duty(mod_i[c]);
              arm_d[c] = (arm_i[c] >= ARM_HALF);
            end
            MODE_FM: begin
              pend_per_d[c] = mod_i[c][CNT_W-1:0];
            end
            default: begin
              pend_d[c] = 1'b0;
            end
          endcase
        end
      end
      hi_d[c] = hi_len(period_d[c], duty_d[c]);
      if (runs(run_d[c], mode_d[c], arm_d[c], period_d[c]) && (cnt_d[c] < hi_d[c])) begin
        out_d[c] = level_d[c];
      end else begin
        out_d[c] = !level_d[c];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        mode_q[c] <= MODE_PWM;
        base_q[c] <= BASE_1M;
      end
      cnt_q <= '0;
      period_q <= {NUM_CH{PERIOD_RST}};
      duty_q <= {NUM_CH{DUTY_RST}};
      hi_q <= '0;
      pend_per_q <= '0;
      pend_duty_q <= '0;
      level_q <= {NUM_CH{LEVEL_RST}};
      arm_q <= {NUM_CH{ARM_RST}};
      run_q <= '0;
      pend_q <= '0;
      pwm_o <= {NUM_CH{!LEVEL_RST}};
      armed_o <= {NUM_CH{ARM_RST}};
      period_start_o <= '0;
    end else begin
      mode_q <= mode_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      period_q <= period_d;
      duty_q <= duty_d;
      hi_q <= hi_d;
      pend_per_q <= pend_per_d;
      pend_duty_q <= pend_duty_d;
      level_q <= level_d;
      arm_q <= arm_d;
      run_q <= run_d;
      pend_q <= pend_d;
      pwm_o <= out_d;
      armed_o <= arm_d;
      period_start_o <= start_d;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    wire go_w = runs(run_q[c], mode_q[c], arm_q[c], period_q[c]);
    wire last_w = go_w && tick[base_q[c]] && (cnt_q[c] == CNT_W'(period_q[c] - 1'b1));

    sequence seq_arm_update;
      mod_valid_i[c] && run_q[c] && (mode_q[c] == MODE_PWM_ARM) && !load_i[c];
    endsequence

    // output level tracks counter and leading length
    chk_out_shape: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pwm_o[c] == ((go_w && (cnt_q[c] < hi_q[c])) ? level_q[c] : !level_q[c]))
      else $error("output level does not match counter position");

    // stopped channel idles, restart opens a period
    chk_stop_inactive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!go_w && !load_i[c]) |=> (cnt_q[c] == '0)
        && (pwm_o[c] == ((go_w && (hi_q[c] != '0)) ? level_q[c] : !level_q[c])))
      else $error("stopped channel not held inactive");

    chk_arm_threshold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      seq_arm_update |=> (arm_q[c] == ($past(arm_i[c]) >= ARM_HALF)) && (armed_o[c] == arm_q[c]))
      else $error("arm state wrong after update");

    chk_load_arm: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      load_i[c] |=> (arm_q[c] == $past(arm_init_i[c])) && (cnt_q[c] == '0) && run_q[c])
      else $error("load did not set arm state");

    // duty and period of a running channel only move at a period boundary, apart from a load
    chk_boundary_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (go_w && !last_w && !load_i[c]) |=> $stable(duty_q[c]) && $stable(period_q[c]))
      else $error("setting changed inside a period");

    // counter wraps to zero with a start pulse after its last tick
    chk_count_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (last_w && !load_i[c]) |=> (cnt_q[c] == '0) && period_start_o[c])
      else $error("counter did not wrap at period end");

    // duty moves in frequency mode only on a load
    chk_fm_duty_fixed: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run_q[c] && (mode_q[c] == MODE_FM) && !load_i[c]) |=> $stable(duty_q[c]))
      else $error("duty changed in frequency mode");

    chk_load_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      load_i[c] |=> hi_q[c] == hi_len($past(period_i[c]), $past(duty_i[c])))
      else $error("leading length wrong after load");

    // frequency update lands in the pending period
    chk_fm_pending: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (mod_valid_i[c] && run_q[c] && (mode_q[c] == MODE_FM) && !load_i[c])
        |=> pend_q[c] && (pend_per_q[c] == $past(mod_i[c][CNT_W-1:0])))
      else $error("frequency update not held pending");
  end
endmodule // cpfg_top

// ---- cpfg_host.sv ----
`timescale 1ns/100ps
module cpfg_host (
  input wire logic ref_clk_i,
  output logic [cpfg_pkg::NUM_CH-1:0] load_o,
  output cpfg_pkg::cpfg_mode_e mode_o [cpfg_pkg::NUM_CH],
  output cpfg_pkg::cpfg_base_e base_o [cpfg_pkg::NUM_CH],
  output logic [4:0][15:0] per_o,
  output logic [4:0][16:0] duty_o,
  output logic [4:0] lvl_o,
  output logic [4:0] ainit_o,
  output logic [4:0] mv_o,
  output logic [4:0][16:0] mod_o,
  output logic [4:0][15:0] arm_o
);
  import cpfg_pkg::*;
  initial begin
    load_o = '0;
    per_o = '0;
    duty_o = '0;
    lvl_o = '0;
    ainit_o = '0;
    mv_o = '0;
    mod_o = '0;
    arm_o = '0;
    foreach (mode_o[i]) begin
      mode_o[i] = MODE_PWM;
      base_o[i] = BASE_1M;
    end
  end
  task automatic load(input int c, input cpfg_mode_e m, input cpfg_base_e b, input logic [15:0] p,
                      input logic [16:0] d, input logic l, input logic a);
    @(negedge ref_clk_i);
    mode_o[c] = m;
    base_o[c] = b;
    per_o[c] = p;
    duty_o[c] = d;
    lvl_o[c] = l;
    ainit_o[c] = a;
    load_o[c] = 1'h1;
    @(negedge ref_clk_i);
    load_o[c] = 1'h0;
  endtask
  task automatic upd(input int c, input logic [16:0] v, input logic [15:0] a);
    @(negedge ref_clk_i);
    mod_o[c] = v;
    arm_o[c] = a;
    mv_o[c] = 1'h1;
    @(negedge ref_clk_i);
    mv_o[c] = 1'h0;
    // released lines show garbage
    mod_o[c] = ~v;
    arm_o[c] = ~a;
  endtask
endmodule // cpfg_host

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import cpfg_pkg::*;
  logic clk;
  logic rst;
  logic [4:0] ld, lvl, ai, mv, pwm, armd, ps;
  cpfg_mode_e md [5];
  cpfg_base_e bs [5];
  logic [4:0][15:0] per, arm;
  logic [4:0][16:0] dty, mdv;
  int n_mismatch = 0;
  int check_count = 0;
  localparam int WAIT_MAX = 45000;
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  cpfg_host host (.ref_clk_i(clk), .load_o(ld), .mode_o(md), .base_o(bs), .per_o(per), .duty_o(dty),
    .lvl_o(lvl), .ainit_o(ai), .mv_o(mv), .mod_o(mdv), .arm_o(arm));
  cpfg_top DUT (.ref_clk_i(clk), .rst_i(rst), .load_i(ld), .mode_i(md), .base_i(bs), .period_i(per),
    .duty_i(dty), .level_i(lvl), .arm_init_i(ai), .mod_valid_i(mv), .mod_i(mdv), .arm_i(arm),
    .pwm_o(pwm), .armed_o(armd), .period_start_o(ps));
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= WAIT_MAX) begin
      n_mismatch++;
      $display("BAD wait expected pulse seen none");
      stop_test();
    end
  endtask
  // one period between start pulses, counting leading level
  task automatic meas(input int c, input logic l, input int ep, input int eh);
    int n;
    int h;
    n = 0;
    h = 0;
    while (ps[c] !== 1'h1 && n < WAIT_MAX) begin
      @(negedge clk);
      n++;
    end
    tmo(n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      h += int'(pwm[c] === l);
    end while (ps[c] !== 1'h1 && n < WAIT_MAX);
    tmo(n);
    chk("period", ep, n);
    chk("lead", eh, h);
  endtask
  initial begin
    rst = 1'h1;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk("pwm_rst", 32'h1F, pwm);
    chk("armed_rst", 32'h0, armd);
    for (int b = 0; b < NUM_BASE; b++) begin
      host.load(4, MODE_PWM, cpfg_base_e'(b), 16'h0001, 17'h10000, b[0], 1'h0);
      @(negedge clk);
      chk("base_lead", b[0], pwm[4]); // every base code
    end
    host.load(0, MODE_PWM, BASE_1M, 16'h0004, 17'h04000, 1'h1, 1'h0);
    host.load(1, MODE_PWM, BASE_100K, 16'h0002, 17'h08000, 1'h0, 1'h0);
    host.load(2, MODE_FM, BASE_1M, 16'h0002, 17'h08000, 1'h1, 1'h0);
    host.load(3, MODE_PWM_ARM, BASE_1M, 16'h0002, 17'h08000, 1'h1, 1'h0);
    @(negedge clk);
    chk("armed_init", 32'h0, armd[3]); // starts disarmed
    chk("pwm_disarm", 32'h0, pwm[3]); // idle while disarmed
    meas(0, 1'h1, 4 * REF_DIV, REF_DIV); // quarter duty
    meas(1, 1'h0, 2 * REF_DIV * DECADE, REF_DIV * DECADE); // slower base
    meas(2, 1'h1, 2 * REF_DIV, REF_DIV); // start rate
    host.upd(0, 17'h0C000, 16'h0000);
    meas(0, 1'h1, 4 * REF_DIV, 3 * REF_DIV); // new duty
    host.upd(2, 17'h00004, 16'h0000);
    meas(2, 1'h1, 4 * REF_DIV, 2 * REF_DIV); // new rate
    host.upd(3, 17'h08000, 16'h7FFF);
    @(negedge clk);
    chk("armed_low", 32'h0, armd[3]); // below half
    chk("pwm_low", 32'h0, pwm[3]); // still idle
    host.upd(3, 17'h08000, 16'h8000);
    @(negedge clk);
    chk("armed_half", 32'h1, armd[3]); // half arms
    meas(3, 1'h1, 2 * REF_DIV, REF_DIV); // waveform resumes
    host.upd(3, 17'h08000, 16'h0000);
    @(negedge clk);
    chk("armed_off", 32'h0, armd[3]); // disarm again
    chk("pwm_off", 32'h0, pwm[3]); // back to idle
    host.load(4, MODE_PWM, BASE_10K, 16'h0001, 17'h10000, 1'h1, 1'h0);
    meas(4, 1'h1, REF_DIV * DECADE * DECADE, REF_DIV * DECADE * DECADE); // decade chain rate
    stop_test();
  end
endmodule // testbench
